/* File: logic/adcc_control.sv */
// Purpose: first control register of a successive-approximation converter and its sequencer
// Assumes: AHB-Lite slave with zero wait states; 10-bit raw result from the analog side
// Notes: sample time counts clock cycles; result reads step through the buffer
//
// What this block does
// RULE1: the converter runs only while converter_on is one and is off otherwise.
// RULE2: with idle_stop set the converter halts while the device is idle.
// RULE3: format 11 gives signed fractional and 10 unsigned fractional, left justified.
// RULE4: format 01 gives a sign-extended integer and 00 a zero-extended integer.
// RULE5: trigger code 111 lets the internal sample counter end sampling.
// RULE6: trigger code 010 ends sampling on a timer compare event.
// RULE7: trigger code 001 ends sampling on an edge of the external interrupt zero pin.
// RULE8: codes 011 to 110 are reserved, and code 000 ends sampling when software clears sample.
// RULE9: with auto_sample_start set a new sampling phase begins after each conversion.
// RULE10: without auto_sample_start sampling begins only when sample_enable is set.
// RULE11: sample_enable reads one while acquiring and zero while holding.
// RULE12: the done flag reads one once a conversion has finished.
// RULE13: done clears when sampling starts from hold or off and sets when the result is stored.
// RULE14: result buffers are wiped when converter_on is cleared.
// RULE15: software should read results before turning the converter off.
// RULE16: bits 14, 12 to 10 and 4 to 3 read as zero.
`timescale 1ns/1ps
`include "adcc_map.svh"
module adcc_control #(
  parameter int CONV_CYC = `ADCC_CONV_CYC,
  parameter int DEPTH = `ADCC_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // device and trigger inputs
  input wire logic i_idle,
  input wire logic i_timer_compare,
  input wire logic i_external_interrupt_zero_pin,
  input wire logic [9:0] i_raw_result,
  // analog side
  output adcc_pkg::adcc_analog_s o_analog,
  // interrupt
  output logic o_irq
);

  localparam int AW = $clog2(DEPTH);

  adcc_pkg::adcc_ctrl_s ctrl_reg;
  adcc_pkg::adcc_state_e state_reg;
  logic sample_reg;
  logic done_reg;
  logic [7:0] sample_time_reg;
  logic [7:0] sample_enable_cnt_reg;
  logic [15:0] conv_cnt_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic pin_d_reg;
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] addr_reg;
  logic [15:0] buf_rdata;
  logic run;
  logic end_sample;
  logic conv_end;
  logic sample_start;
  logic wr_ctrl;
  logic rd_stat;
  logic rd_result;
  logic addr_ok;
  logic [15:0] ctrl_read;
  logic [15:0] fmt_result;

  function automatic logic [15:0] fmt_word(input adcc_pkg::adcc_fmt_e f, input logic [9:0] d);
    logic [15:0] w;
    w = 16'h0000;
    case (f)
      adcc_pkg::FMT_INT: w = {6'h00, d};
      adcc_pkg::FMT_SINT: w = {{6{~d[9]}}, ~d[9], d[8:0]};
      adcc_pkg::FMT_FRAC: w = {d, 6'h00};
      adcc_pkg::FMT_SFRAC: w = {~d[9], d[8:0], 6'h00};
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  function automatic logic word_ok(input logic [7:0] a);
    return a == `ADCC_OFF_CTRL || a == `ADCC_OFF_RESULT || a == `ADCC_OFF_IRQ_STAT
      || a == `ADCC_OFF_IRQ_MASK || a == `ADCC_OFF_SAMPLE_TIME;
  endfunction

  // ahb address phase capture
  assign addr_ok = i_hsel && i_hready && i_htrans[1];

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= addr_ok && i_hwrite && word_ok(i_haddr);
      rd_pend_reg <= addr_ok && !i_hwrite;
      if (addr_ok)
      begin
        addr_reg <= i_haddr;
      end
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign wr_ctrl = wr_pend_reg && addr_reg == `ADCC_OFF_CTRL;
  assign rd_stat = rd_pend_reg && addr_reg == `ADCC_OFF_IRQ_STAT;
  assign rd_result = addr_ok && !i_hwrite && i_haddr == `ADCC_OFF_RESULT;

  // RULE1: converter enable
  // RULE2: idle halt
  assign run = ctrl_reg.on && !(ctrl_reg.idle_stop && i_idle);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ctrl_reg <= '0;
    end
    else if (wr_ctrl)
    begin
      ctrl_reg.on <= i_hwdata[`ADCC_BIT_ON];
      ctrl_reg.idle_stop <= i_hwdata[`ADCC_BIT_IDLE_STOP];
      ctrl_reg.output_format <= adcc_pkg::adcc_fmt_e'(i_hwdata[`ADCC_OUTPUT_FORMAT_HI:`ADCC_OUTPUT_FORMAT_LO]);
      ctrl_reg.trigger_source_select <=
        adcc_pkg::adcc_trig_e'(i_hwdata[`ADCC_TRIG_HI:`ADCC_TRIG_LO]);
      ctrl_reg.auto_sample_start <= i_hwdata[`ADCC_BIT_AUTO];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sample_time_reg <= `ADCC_SAMPLE_TIME_RESET;
      irq_mask_reg <= 2'h0;
    end
    else if (wr_pend_reg)
    begin
      if (addr_reg == `ADCC_OFF_SAMPLE_TIME)
      begin
        sample_time_reg <= i_hwdata[7:0];
      end
      if (addr_reg == `ADCC_OFF_IRQ_MASK)
      begin
        irq_mask_reg <= i_hwdata[1:0];
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      pin_d_reg <= 1'b0;
    end
    else
    begin
      pin_d_reg <= i_external_interrupt_zero_pin;
    end
  end

  // end-of-sampling trigger selection
  always_comb
  begin
    end_sample = 1'b0;
    case (ctrl_reg.trigger_source_select)
      // RULE8: manual clear of sample ends it
      adcc_pkg::TRIG_MANUAL: end_sample = wr_ctrl && !i_hwdata[`ADCC_BIT_SAMPLE];
      // RULE7: rising pin edge
      adcc_pkg::TRIG_EXT_INT: end_sample = i_external_interrupt_zero_pin && !pin_d_reg;
      // RULE6: timer compare
      adcc_pkg::TRIG_TIMER: end_sample = i_timer_compare;
      // RULE5: internal sample counter
      adcc_pkg::TRIG_COUNTER: end_sample = sample_enable_cnt_reg >= sample_time_reg;
      default: end_sample = 1'b0;
    endcase
  end

  assign conv_end = state_reg == adcc_pkg::ST_CONVERT && conv_cnt_reg == 16'(CONV_CYC - 1);
  // RULE10: manual start
  assign sample_start = state_reg == adcc_pkg::ST_HOLD && wr_ctrl && i_hwdata[`ADCC_BIT_SAMPLE];

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= adcc_pkg::ST_OFF;
    end
    else if (!run)
    begin
      state_reg <= ctrl_reg.on ? state_reg : adcc_pkg::ST_OFF;
    end
    else
    begin
      case (state_reg)
        adcc_pkg::ST_OFF: state_reg <= ctrl_reg.auto_sample_start ? adcc_pkg::ST_SAMPLE
                                                                  : adcc_pkg::ST_HOLD;
        adcc_pkg::ST_HOLD:
        begin
          if (sample_start || ctrl_reg.auto_sample_start)
          begin
            state_reg <= adcc_pkg::ST_SAMPLE;
          end
        end
        adcc_pkg::ST_SAMPLE:
        begin
          if (end_sample)
          begin
            state_reg <= adcc_pkg::ST_CONVERT;
          end
        end
        adcc_pkg::ST_CONVERT:
        begin
          // RULE9: auto restart
          if (conv_end)
          begin
            state_reg <= ctrl_reg.auto_sample_start ? adcc_pkg::ST_SAMPLE : adcc_pkg::ST_HOLD;
          end
        end
        default: state_reg <= adcc_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || state_reg != adcc_pkg::ST_SAMPLE || !run)
    begin
      sample_enable_cnt_reg <= 8'h00;
    end
    else if (sample_enable_cnt_reg != 8'hff)
    begin
      sample_enable_cnt_reg <= sample_enable_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || state_reg != adcc_pkg::ST_CONVERT)
    begin
      conv_cnt_reg <= 16'h0000;
    end
    else if (run)
    begin
      conv_cnt_reg <= conv_cnt_reg + 16'h0001;
    end
  end

  // RULE11: sample flag follows acquire phase
  always_comb
  begin
    sample_reg = state_reg == adcc_pkg::ST_SAMPLE;
  end

  // RULE12: done status
  // RULE13: clear on new sample, set on store
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      done_reg <= 1'b0;
    end
    else if (run && conv_end)
    begin
      done_reg <= 1'b1;
    end
    else if (run && state_reg != adcc_pkg::ST_SAMPLE && state_reg_to_sample(state_reg))
    begin
      done_reg <= 1'b0;
    end
  end

  function automatic logic state_reg_to_sample(input adcc_pkg::adcc_state_e s);
    return (s == adcc_pkg::ST_HOLD && (sample_start || ctrl_reg.auto_sample_start))
      || (s == adcc_pkg::ST_OFF && ctrl_reg.auto_sample_start);
  endfunction

  // RULE3: fractional formats
  // RULE4: integer formats
  assign fmt_result = fmt_word(ctrl_reg.output_format, i_raw_result);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || !ctrl_reg.on)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end
    else
    begin
      if (run && conv_end)
      begin
        wptr_reg <= AW'(wptr_reg + 1'b1);
      end
      if (rd_result)
      begin
        rptr_reg <= AW'(rptr_reg + 1'b1);
      end
    end
  end

  // RULE14: buffer wiped when off
  adcc_result_mem #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(!ctrl_reg.on),
    .i_we(run && conv_end),
    .i_waddr(wptr_reg),
    .i_wdata(fmt_result),
    .i_raddr(rptr_reg),
    .o_rdata(buf_rdata)
  );

  // sticky events, set wins over read clear
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      irq_stat_reg <= 2'h0;
    end
    else
    begin
      irq_stat_reg[`ADCC_IRQ_DONE] <= (run && conv_end) || (irq_stat_reg[`ADCC_IRQ_DONE] && !rd_stat);
      irq_stat_reg[`ADCC_IRQ_TRIG] <= (run && state_reg == adcc_pkg::ST_SAMPLE && end_sample)
        || (irq_stat_reg[`ADCC_IRQ_TRIG] && !rd_stat);
    end
  end

  assign o_irq = |(irq_stat_reg & irq_mask_reg);

  // RULE16: unimplemented bits zero
  assign ctrl_read = {ctrl_reg.on, 1'b0, ctrl_reg.idle_stop, 3'h0, ctrl_reg.output_format,
    ctrl_reg.trigger_source_select, 2'h0, ctrl_reg.auto_sample_start, sample_reg, done_reg};

  always_comb
  begin
    o_hrdata = 32'h0000_0000;
    if (rd_pend_reg)
    begin
      case (addr_reg)
        `ADCC_OFF_CTRL: o_hrdata = {16'h0000, ctrl_read};
        `ADCC_OFF_RESULT: o_hrdata = {16'h0000, buf_rdata};
        `ADCC_OFF_IRQ_STAT: o_hrdata = {30'h0, irq_stat_reg};
        `ADCC_OFF_IRQ_MASK: o_hrdata = {30'h0, irq_mask_reg};
        `ADCC_OFF_SAMPLE_TIME: o_hrdata = {24'h0, sample_time_reg};
        default: o_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_analog <= '0;
    end
    else
    begin
      o_analog.sh_sample <= ctrl_reg.on && state_reg == adcc_pkg::ST_SAMPLE;
      o_analog.conv_start <= run && state_reg == adcc_pkg::ST_SAMPLE && end_sample;
    end
  end

endmodule

/* File: logic/adcc_map.svh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes: included by bare name
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

`define ADCC_OFF_CTRL 8'h00
`define ADCC_OFF_RESULT 8'h04
`define ADCC_OFF_IRQ_STAT 8'h08
`define ADCC_OFF_IRQ_MASK 8'h0c
`define ADCC_OFF_SAMPLE_TIME 8'h10

`define ADCC_BIT_ON 15
`define ADCC_BIT_IDLE_STOP 13
`define ADCC_OUTPUT_FORMAT_HI 9
`define ADCC_OUTPUT_FORMAT_LO 8
`define ADCC_TRIG_HI 7
`define ADCC_TRIG_LO 5
`define ADCC_BIT_AUTO 2
`define ADCC_BIT_SAMPLE 1
`define ADCC_BIT_DONE 0
`define ADCC_CTRL_WMASK 16'ha3e6

`define ADCC_CTRL_RESET 16'h0000
`define ADCC_SAMPLE_TIME_RESET 8'h10

`define ADCC_IRQ_DONE 0
`define ADCC_IRQ_TRIG 1

`define ADCC_CLK_MHZ 40
`define ADCC_CONV_NS 500
`define ADCC_CONV_CYC ((`ADCC_CONV_NS * `ADCC_CLK_MHZ + 999) / 1000)
`define ADCC_DEPTH 4

`endif

/* File: logic/adcc_pkg.sv */
// Purpose: shared types of the converter control block
// Assumes: constants live in adcc_map.svh
// Notes: no imports, use adcc_pkg::name
package adcc_pkg;

  typedef enum logic [2:0] {
    TRIG_MANUAL,
    TRIG_EXT_INT,
    TRIG_TIMER,
    TRIG_R3,
    TRIG_R4,
    TRIG_R5,
    TRIG_R6,
    TRIG_COUNTER
  } adcc_trig_e;

  typedef enum logic [1:0] {
    FMT_INT,
    FMT_SINT,
    FMT_FRAC,
    FMT_SFRAC
  } adcc_fmt_e;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_HOLD,
    ST_SAMPLE,
    ST_CONVERT
  } adcc_state_e;

  typedef struct packed {
    logic on;
    logic idle_stop;
    adcc_fmt_e output_format;
    adcc_trig_e trigger_source_select;
    logic auto_sample_start;
  } adcc_ctrl_s;

  typedef struct packed {
    logic sh_sample;
    logic conv_start;
  } adcc_analog_s;

endpackage

/* File: logic/adcc_result_mem.sv */
// Purpose: result buffer memory with registered read data
// Assumes: one write and one read port on one clock
// Notes: clear wipes every word and the read register
`timescale 1ns/1ps
module adcc_result_mem #(
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_clear,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [15:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [15:0] o_rdata
);

  logic [15:0] mem_reg [DEPTH];

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || i_clear)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_reg[i] <= 16'h0000;
      end
    end
    else if (i_we)
    begin
      mem_reg[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || i_clear)
    begin
      o_rdata <= 16'h0000;
    end
    else
    begin
      o_rdata <= mem_reg[i_raddr];
    end
  end

endmodule

/* File: test/adcc_control_asserts.sv */
// Purpose: port checks of the converter control block
// Assumes: zero-wait bus slave; control word shadowed from bus writes
// Notes: bound into adcc_control below
`timescale 1ns/1ps
module adcc_control_asserts (
  // clock, reset and bus
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  // device side
  input wire logic i_idle,
  input wire logic i_timer_compare,
  input wire logic i_external_interrupt_zero_pin,
  input wire adcc_pkg::adcc_analog_s o_analog
);
  logic ap;
  logic wr_reg;
  logic rd_reg;
  logic [15:0] ctl_reg;
  logic sh;
  logic cs;
  logic [2:0] trg;
  assign ap = i_hsel && i_hready && i_htrans[1] && i_haddr == 8'h00;
  assign sh = o_analog.sh_sample;
  assign cs = o_analog.conv_start;
  assign trg = ctl_reg[7:5];
  always_ff @(posedge i_clk)
  begin
    wr_reg <= i_rst_n && ap && i_hwrite;
    rd_reg <= i_rst_n && ap && !i_hwrite;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      ctl_reg <= 16'h0000;
    else if (wr_reg)
      ctl_reg <= i_hwdata[15:0];
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_OFF_QUIET: assert property (!ctl_reg[15] && !$past(ctl_reg[15]) |-> !sh && !cs)
    else $error("converter active while off");
  AST_IDLE_FREEZE: assert property ($past(i_idle) && $past(ctl_reg[13]) |-> $stable(sh))
    else $error("sampling moved while idle");
  AST_RSVD_ZERO: assert property (rd_reg |-> (o_hrdata & 32'hffff5c18) == 32'h0)
    else $error("unused control bits not zero");
  AST_START_AFTER_SAMPLE: assert property (cs |-> sh ##1 !sh)
    else $error("conversion start without sampling end");
  AST_EXT_EDGE: assert property (ctl_reg[15] && trg == 3'b001 && sh &&
    $rose(i_external_interrupt_zero_pin) |-> ##[1:4] cs)
    else $error("pin edge did not end sampling");
  AST_TIMER_END: assert property (ctl_reg[15] && trg == 3'b010 && sh &&
    i_timer_compare |-> ##[1:3] cs)
    else $error("timer event did not end sampling");
  AST_MANUAL_END: assert property (wr_reg && ctl_reg[15] && trg == 3'b000 && sh &&
    i_hwdata[15] && !i_hwdata[1] && i_hwdata[7:5] == 3'b000 |-> ##[1:3] cs)
    else $error("clearing sample did not start conversion");
  AST_AUTO_RESTART: assert property (ctl_reg[15] && ctl_reg[2] && cs |-> ##[1:40] sh)
    else $error("auto start did not resume sampling");
  AST_HOLD_MANUAL: assert property (!ctl_reg[2] && !sh && !wr_reg && !$past(wr_reg)
    |=> !sh)
    else $error("sampling began without request");
endmodule

bind adcc_control adcc_control_asserts u_chk (.i_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans,
  .i_hwrite, .i_hwdata, .i_hready, .o_hrdata, .i_idle, .i_timer_compare,
  .i_external_interrupt_zero_pin, .o_analog);

/* File: test/adcc_control_tb.sv */
// Purpose: self-checking bench of the converter control block
// Assumes: zero-wait bus slave, short conversion count
// Notes: reads queue expected words, a monitor compares them
`timescale 1ns/1ps
`include "adcc_map.svh"
module adcc_control_tb;
  localparam int CC = 2;
  localparam logic [7:0] RC = `ADCC_OFF_CTRL;
  localparam logic [7:0] RR = `ADCC_OFF_RESULT;
  localparam logic [7:0] RS = `ADCC_OFF_IRQ_STAT;
  localparam logic [7:0] RM = `ADCC_OFF_IRQ_MASK;
  localparam logic [7:0] RT = `ADCC_OFF_SAMPLE_TIME;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hw = 1'b0;
  logic idle = 1'b0;
  logic tmr = 1'b0;
  logic ext = 1'b0;
  logic dp = 1'b0;
  logic [7:0] ha = 8'h00;
  logic [1:0] ht = 2'h0;
  logic [31:0] wd = 32'h0;
  logic [9:0] raw = 10'h000;
  logic [31:0] rdata;
  logic [31:0] e;
  logic [31:0] c;
  logic [31:0] rs = 32'h00009714;
  logic rdy;
  logic irq;
  logic resp;
  adcc_pkg::adcc_analog_s an;
  logic [31:0] q[$];
  int errors = 0;
  int total_checks = 0;
  int n;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("BAD %0t got %h want %h", $time, (a), (b)); end end

  always #12.5 i_clk = ~i_clk;

  adcc_control #(.CONV_CYC(CC), .DEPTH(4)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_hsel(hsel), .i_haddr(ha), .i_htrans(ht), .i_hwrite(hw), .i_hsize(3'h2),
    .i_hwdata(wd), .i_hready(rdy), .o_hrdata(rdata), .o_hreadyout(rdy), .o_hresp(resp),
    .i_idle(idle), .i_timer_compare(tmr), .i_external_interrupt_zero_pin(ext),
    .i_raw_result(raw), .o_analog(an), .o_irq(irq));

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic logic [31:0] fx(input logic [9:0] r, input int f);
    logic [9:0] s;
    s = r ^ 10'h200;
    case (f)
      0: return {22'h0, r};
      1: return {16'h0, {6{s[9]}}, s};
      2: return {16'h0, r, 6'h00};
      default: return {16'h0, s, 6'h00};
    endcase
  endfunction

  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    ha <= a;
    hw <= w;
    ht <= 2'h2;
    do @(posedge i_clk); while (rdy !== 1'b1);
    ht <= 2'h0;
    wd <= d;
    do @(posedge i_clk); while (rdy !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    q.push_back(x);
    xf(1'b0, a, 32'h0);
  endtask

  // counts cycles up to a conversion start, ends on a rising edge
  task automatic waitcs();
    n = 0;
    @(negedge i_clk);
    while (an.conv_start !== 1'b1 && n < 200)
    begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
  endtask

  task give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge i_clk)
  begin
    if (dp && q.size() > 0)
    begin
      e = q.pop_front();
      `CHK(rdata, e)
      `CHK(resp, 1'b0)
    end
    dp <= i_rst_n && hsel && rdy && ht[1] && !hw;
  end

  initial
  begin
    #100us;
    errors++;
    give_verdict();
  end

  initial
  begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rd(RC, 32'h0);
    rd(RS, 32'h0);
    rd(RM, 32'h0);
    rd(RT, 32'h10);
    rd(8'h14, 32'h0);
    c = rnd() & 32'hffff7ffd;
    xf(1'b1, RC, c);
    rd(RC, c & 32'h23e4);
    $display("test reset and access done");
    for (int f = 0; f < 4; f++)
    begin
      c = 32'h8000 | (f << 8);
      raw <= 10'(rnd());
      xf(1'b1, RM, 32'(f & 1));
      xf(1'b1, RC, c);
      xf(1'b1, RC, c | 32'h2);
      rd(RC, c | 32'h2);
      xf(1'b1, RC, c);
      repeat (CC + 4) @(posedge i_clk);
      rd(RR, fx(raw, f));
      rd(RC, c | 32'h1);
      @(negedge i_clk);
      `CHK(irq, 1'(f & 1))
      @(posedge i_clk);
      rd(RS, 32'h3);
      @(negedge i_clk);
      `CHK(irq, 1'b0)
      @(posedge i_clk);
    end
    $display("test formats and manual trigger done");
    for (int t = 1; t < 3; t++)
    begin
      c = 32'h8000 | (t << 5);
      xf(1'b1, RC, c | 32'h2);
      repeat (3) @(posedge i_clk);
      ext <= (t == 1);
      tmr <= (t == 2);
      @(posedge i_clk);
      ext <= 1'b0;
      tmr <= 1'b0;
      repeat (CC + 4) @(posedge i_clk);
      rd(RC, c | 32'h1);
    end
    $display("test pin and timer triggers done");
    xf(1'b1, RT, 32'h4);
    for (int i = 0; i < 2; i++)
    begin
      c = 32'h80e0 | (i << 13);
      xf(1'b1, RC, c | 32'h2);
      @(posedge i_clk);
      idle <= 1'b1;
      repeat (10) @(posedge i_clk);
      @(negedge i_clk);
      `CHK(an.sh_sample, 1'(i))
      @(posedge i_clk);
      idle <= 1'b0;
      if (i == 1)
        waitcs();
      if (i == 1)
        `CHK(n <= 6, 1'b1)
      repeat (CC + 4) @(posedge i_clk);
      rd(RC, c | 32'h1);
    end
    $display("test counter and idle done");
    xf(1'b1, RC, 32'h80e6);
    waitcs();
    waitcs();
    `CHK(n < 40, 1'b1)
    // turn off while sampling so no started conversion is cut short
    while (an.sh_sample !== 1'b1)
      @(posedge i_clk);
    xf(1'b1, RC, 32'h0);
    rd(RR, 32'h0);
    repeat (2) @(posedge i_clk);
    $display("test auto start and wipe done");
    give_verdict();
  end
endmodule
